// *** pkg/gde_pkg.sv ***
// Register map and field layout of the dual-edge pad I/O logic
package gde_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] GDE_CFG_OFS = 8'h00;
  localparam logic [7:0] GDE_STAT_OFS = 8'h04;
  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  localparam int GDE_CFG_IN_REG = 0;
  localparam int GDE_CFG_OUT_REG = 1;
  localparam int GDE_CFG_OE_REG = 2;
  localparam int GDE_CFG_IN_FALL = 3;
  localparam int GDE_CFG_OUT_FALL = 4;
  localparam int GDE_CFG_OE_FALL = 5;
  localparam int GDE_CFG_DUAL = 6;
  localparam int GDE_CFG_RESYNC = 7;
  localparam int GDE_CFG_INVERT = 8;
  localparam int GDE_CFG_ROUTE_LSB = 9;
  localparam int GDE_CFG_W = 11;
  localparam logic [10:0] GDE_CFG_RST = 11'h000;
  // ----------------------------------------
  // Bypass routes
  // ----------------------------------------
  typedef enum logic [1:0] {
    GDE_RT_CLOCK = 2'h0,
    GDE_RT_CONTROL = 2'h1,
    GDE_RT_SYNTH = 2'h2,
    GDE_RT_CAMERA = 2'h3
  } gde_route_t;
  // ----------------------------------------
  // Status fields
  // ----------------------------------------
  localparam int GDE_ST_PAD_IN = 0;
  localparam int GDE_ST_PAD_OE = 1;
  localparam int GDE_ST_PAD_OUT = 2;
  localparam int GDE_ST_CAP_LSB = 3;
  localparam int GDE_ST_DUAL_ON = 5;
endpackage

// *** logic/gde_io_logic.sv ***
// Dual-edge pad I/O logic with register port and bypass input routing
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
// Function
// - capture bit0 normal input; dual: rise/fall
// - drive bit0 normal; dual: rise/fall halves
// - bypass path registered once on core clock, routed to global nets or reference inputs
// - drive enable optionally registered before pad
// - output and enable registers use launch clock
// - capture registers use separate capture clock
// - dual mode samples both edges, 2-bit words
// - normal dual mode hands values per edge
// - resync dual mode exchanges on rising only
// - resync falling value delayed half cycle
// - single-ended differential pads lack dual mode
// - paths optional registers, selectable trigger edge
// - output register can invert pad value
module gde_io_logic #(
  parameter bit SE_DIFF_PAD = 1'b0
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Core clocks, sampled as levels
  input wire logic capture_clock,
  input wire logic launch_clock,
  // Core data
  input wire logic [1:0] drive_data,
  input wire logic drive_enable,
  output logic [1:0] capture_data,
  // Bypass destinations
  output logic global_clock_net,
  output logic global_control_net,
  output logic synth_reference_in,
  output logic camera_link_reference_in,
  // Pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe
);

  // ----------------------------------------
  // Edge decode
  // ----------------------------------------
  function automatic logic edge_hit(input logic on_fall, input logic rise, input logic fall);
    edge_hit = on_fall ? fall : rise;
  endfunction

  logic [10:0] cfg_reg, cfg_next;
  logic [31:0] rdata_reg, rdata_next;
  logic cap_prev_reg, cap_prev_next;
  logic lau_prev_reg, lau_prev_next;
  logic [1:0] cap_reg, cap_next;
  logic fall_hold_reg, fall_hold_next;
  logic out_hold_reg, out_hold_next;
  logic out_reg, out_next;
  logic oe_reg, oe_next;
  logic [3:0] byp_reg, byp_next;
  logic cap_rise, cap_fall, lau_rise, lau_fall;
  logic dual_on, resync;

  assign cap_rise = capture_clock & ~cap_prev_reg;
  assign cap_fall = ~capture_clock & cap_prev_reg;
  assign lau_rise = launch_clock & ~lau_prev_reg;
  assign lau_fall = ~launch_clock & lau_prev_reg;
  assign dual_on = cfg_reg[gde_pkg::GDE_CFG_DUAL] & ~SE_DIFF_PAD;
  assign resync = cfg_reg[gde_pkg::GDE_CFG_RESYNC];

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    rdata_next = 32'h0000_0000;
    if (reg_wr && reg_addr == gde_pkg::GDE_CFG_OFS) begin
      cfg_next = reg_wdata[10:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        gde_pkg::GDE_CFG_OFS: rdata_next = {21'h00_0000, cfg_reg};
        gde_pkg::GDE_STAT_OFS: rdata_next = {26'h000_0000, dual_on, cap_reg,
                                             out_reg, oe_reg, pad_in};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_reg <= gde_pkg::GDE_CFG_RST;
      rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Input path
  // ----------------------------------------
  always_comb begin
    cap_prev_next = capture_clock;
    cap_next = cap_reg;
    fall_hold_next = fall_hold_reg;
    if (dual_on) begin
      if (resync) begin
        if (cap_fall) begin
          fall_hold_next = pad_in;
        end
        if (cap_rise) begin
          cap_next = {fall_hold_reg, pad_in};
        end
      end else begin
        if (cap_rise) begin
          cap_next[0] = pad_in;
        end
        if (cap_fall) begin
          cap_next[1] = pad_in;
        end
      end
    end else if (cfg_reg[gde_pkg::GDE_CFG_IN_REG]) begin
      if (edge_hit(cfg_reg[gde_pkg::GDE_CFG_IN_FALL], cap_rise, cap_fall)) begin
        cap_next = {1'b0, pad_in};
      end
    end else begin
      cap_next = {1'b0, pad_in};
    end
  end

  // Bypass taps the pad before any capture register
  always_comb begin
    byp_next = 4'h0;
    unique case (gde_pkg::gde_route_t'(cfg_reg[gde_pkg::GDE_CFG_ROUTE_LSB +: 2]))
      gde_pkg::GDE_RT_CLOCK: byp_next[0] = pad_in;
      gde_pkg::GDE_RT_CONTROL: byp_next[1] = pad_in;
      gde_pkg::GDE_RT_SYNTH: byp_next[2] = pad_in;
      gde_pkg::GDE_RT_CAMERA: byp_next[3] = pad_in;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cap_prev_reg <= 1'b0;
      cap_reg <= 2'h0;
      fall_hold_reg <= 1'b0;
      byp_reg <= 4'h0;
    end else if (ce) begin
      cap_prev_reg <= cap_prev_next;
      cap_reg <= cap_next;
      fall_hold_reg <= fall_hold_next;
      byp_reg <= byp_next;
    end
  end

  // ----------------------------------------
  // Output and enable path
  // ----------------------------------------
  always_comb begin
    lau_prev_next = launch_clock;
    out_next = out_reg;
    out_hold_next = out_hold_reg;
    oe_next = oe_reg;
    if (dual_on) begin
      if (resync) begin
        if (lau_rise) begin
          out_next = drive_data[0] ^ cfg_reg[gde_pkg::GDE_CFG_INVERT];
          out_hold_next = drive_data[1];
        end
        if (lau_fall) begin
          out_next = out_hold_reg ^ cfg_reg[gde_pkg::GDE_CFG_INVERT];
        end
      end else begin
        if (lau_rise) begin
          out_next = drive_data[0] ^ cfg_reg[gde_pkg::GDE_CFG_INVERT];
        end
        if (lau_fall) begin
          out_next = drive_data[1] ^ cfg_reg[gde_pkg::GDE_CFG_INVERT];
        end
      end
    end else if (cfg_reg[gde_pkg::GDE_CFG_OUT_REG]) begin
      if (edge_hit(cfg_reg[gde_pkg::GDE_CFG_OUT_FALL], lau_rise, lau_fall)) begin
        out_next = drive_data[0] ^ cfg_reg[gde_pkg::GDE_CFG_INVERT];
      end
    end else begin
      out_next = drive_data[0];
    end
    if (cfg_reg[gde_pkg::GDE_CFG_OE_REG]) begin
      if (edge_hit(cfg_reg[gde_pkg::GDE_CFG_OE_FALL], lau_rise, lau_fall)) begin
        oe_next = drive_enable;
      end
    end else begin
      oe_next = drive_enable;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lau_prev_reg <= 1'b0;
      out_reg <= 1'b0;
      out_hold_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (ce) begin
      lau_prev_reg <= lau_prev_next;
      out_reg <= out_next;
      out_hold_reg <= out_hold_next;
      oe_reg <= oe_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = rdata_reg;
  assign capture_data = cap_reg;
  assign global_clock_net = byp_reg[0];
  assign global_control_net = byp_reg[1];
  assign synth_reference_in = byp_reg[2];
  assign camera_link_reference_in = byp_reg[3];
  assign pad_out = out_reg;
  assign pad_oe = oe_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_PLAIN_IN: assert property (
    ce && !dual_on && !cfg_reg[gde_pkg::GDE_CFG_IN_REG] |=> capture_data[0] == $past(pad_in))
    else $error("plain input not passed to capture bit 0");

  AST_BYPASS: assert property (
    ce && cfg_reg[gde_pkg::GDE_CFG_ROUTE_LSB +: 2] == 2'h0
    |=> global_clock_net == $past(pad_in) && !synth_reference_in)
    else $error("bypass route wrong");

  AST_OE_DIRECT: assert property (
    ce && !cfg_reg[gde_pkg::GDE_CFG_OE_REG] |=> pad_oe == $past(drive_enable))
    else $error("unregistered enable not passed");

  AST_OE_HOLD: assert property (
    ce && cfg_reg[gde_pkg::GDE_CFG_OE_REG]
    && !edge_hit(cfg_reg[gde_pkg::GDE_CFG_OE_FALL], lau_rise, lau_fall) |=> $stable(pad_oe))
    else $error("registered enable moved off its edge");

  AST_OUT_PLAIN: assert property (
    ce && !dual_on && !cfg_reg[gde_pkg::GDE_CFG_OUT_REG] |=> pad_out == $past(drive_data[0]))
    else $error("unregistered output not passed");

  AST_CAP_HOLD: assert property (
    ce && !dual_on && cfg_reg[gde_pkg::GDE_CFG_IN_REG]
    && !edge_hit(cfg_reg[gde_pkg::GDE_CFG_IN_FALL], cap_rise, cap_fall) |=> $stable(capture_data))
    else $error("capture register moved off its edge");

  AST_OUT_SINGLE: assert property (
    ce && !dual_on && cfg_reg[gde_pkg::GDE_CFG_OUT_REG] && !cfg_reg[gde_pkg::GDE_CFG_OUT_FALL]
    && lau_rise |=> pad_out == $past(drive_data[0] ^ cfg_reg[gde_pkg::GDE_CFG_INVERT]))
    else $error("launch register wrong");

  AST_CAP_SINGLE: assert property (
    ce && !dual_on && cfg_reg[gde_pkg::GDE_CFG_IN_REG] && cfg_reg[gde_pkg::GDE_CFG_IN_FALL]
    && cap_fall |=> capture_data == {1'b0, $past(pad_in)})
    else $error("capture register wrong");

  AST_DUAL_FALL: assert property (
    ce && dual_on && !resync && cap_fall |=> capture_data[1] == $past(pad_in))
    else $error("falling capture missing");

  AST_DUAL_RISE: assert property (
    ce && dual_on && !resync && cap_rise |=> capture_data[0] == $past(pad_in))
    else $error("rising capture missing");

  AST_OUT_FALL: assert property (
    ce && dual_on && !resync && lau_fall
    |=> pad_out == $past(drive_data[1] ^ cfg_reg[gde_pkg::GDE_CFG_INVERT]))
    else $error("falling launch wrong");

  AST_RESYNC_HOLD: assert property (
    ce && dual_on && resync && !cap_rise |=> $stable(capture_data))
    else $error("resync capture changed off rising edge");

  AST_RESYNC_OUT: assert property (
    ce && dual_on && resync && lau_rise
    |=> pad_out == $past(drive_data[0] ^ cfg_reg[gde_pkg::GDE_CFG_INVERT]))
    else $error("resync rising launch wrong");

  AST_RESYNC_LATE: assert property (
    ce && dual_on && resync && cap_fall ##1 (!cap_rise)[*7]
    ##1 (ce && dual_on && resync && cap_rise)
    |=> capture_data[1] == $past(pad_in, 9))
    else $error("resync falling value not delayed");

  AST_SE_PAD: assert property (
    SE_DIFF_PAD |-> !dual_on)
    else $error("dual mode on single-ended pad");

  COV_DUAL: cover property (ce && dual_on && !resync && cap_fall);
  COV_RESYNC: cover property (ce && dual_on && resync && cap_rise);
  COV_OE: cover property (ce && $rose(pad_oe));
  COV_INVERT: cover property (ce && !dual_on && cfg_reg[gde_pkg::GDE_CFG_INVERT] && lau_rise);
  COV_ROUTE: cover property (ce && camera_link_reference_in);
endmodule

// *** tb/gde_core_model.sv ***
// Core-side user logic model: core clocks, drive word and drive enable
`timescale 1ns/10ps
module gde_core_model (
  // Clock
  input wire logic core_clk,
  // Toward the pad cell
  output logic capture_clock,
  output logic launch_clock,
  output logic [1:0] drive_data,
  output logic drive_enable
);
  // ----------------------------------------
  // Stimulus, each level held 4 cycles
  // ----------------------------------------
  initial begin
    capture_clock = 1'b0;
    launch_clock = 1'b0;
    drive_data = 2'h0;
    drive_enable = 1'b0;
  end
  task automatic cap_edge(input logic v);
    @(posedge core_clk);
    capture_clock <= v;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic lau_edge(input logic v);
    @(posedge core_clk);
    launch_clock <= v;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic drive(input logic [1:0] d, input logic en);
    @(posedge core_clk);
    drive_data <= d;
    drive_enable <= en;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the dual-edge pad I/O logic
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_val = 1'b0;
  logic [31:0] reg_rdata, rd;
  logic capture_clock, launch_clock, drive_enable, pad_out, pad_oe, pad_in;
  logic [1:0] drive_data, capture_data;
  logic global_clock_net, global_control_net, synth_reference_in, camera_link_reference_in;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Pad wire: the cell wins while enabled, else the board level
  assign pad_in = pad_oe ? pad_out : ext_val;
  gde_io_logic #(.SE_DIFF_PAD(1'b0)) gde_io_logic_inst (.core_clk, .reset, .ce, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .capture_clock, .launch_clock, .drive_data,
    .drive_enable, .capture_data, .global_clock_net, .global_control_net,
    .synth_reference_in, .camera_link_reference_in, .pad_in, .pad_out, .pad_oe);
  gde_core_model gde_core_model_inst (.core_clk, .capture_clock, .launch_clock,
    .drive_data, .drive_enable);
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_sig(input logic [3:0] got, input logic [3:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_read(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  task automatic cfg(input logic [31:0] d);
    reg_write(gde_pkg::GDE_CFG_OFS, d);
  endtask
  task automatic pad(input logic v);
    @(posedge core_clk);
    ext_val <= v;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic cap(input logic v);
    gde_core_model_inst.cap_edge(v);
  endtask
  task automatic lau(input logic v);
    gde_core_model_inst.lau_edge(v);
  endtask
  task automatic drv(input logic [1:0] d, input logic en);
    gde_core_model_inst.drive(d, en);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    reg_read(8'h00);
    chk_reg(rd, 32'h0, "cfg reset");
    cfg(32'hFFFF_FFFF);
    reg_read(8'h00);
    chk_reg(rd, 32'h0000_07FF, "cfg width");
    reg_read(8'h08);
    chk_reg(rd, 32'h0, "unmapped");
    @(posedge core_clk);
    ce <= 1'b0;
    cfg(32'h0);
    @(posedge core_clk);
    ce <= 1'b1;
    reg_read(8'h00);
    chk_reg(rd, 32'h0000_07FF, "ce freeze");
    cfg(32'h0);
    drv(2'h1, 1'b1);
    chk_sig({pad_oe, pad_out, capture_data}, 4'hD, "driven");
    pad(1'b1);
    drv(2'h0, 1'b0);
    chk_sig({pad_oe, pad_out, capture_data}, 4'h1, "tristate");
    for (int r = 0; r < 4; r++) begin
      cfg(r << 9);
      @(posedge core_clk);
      #1;
      chk_sig({camera_link_reference_in, synth_reference_in, global_control_net,
        global_clock_net}, 4'h1 << r, "route");
    end
    cfg(32'h009);
    cap(1'b1);
    cap(1'b0);
    pad(1'b0);
    chk_sig({2'h0, global_clock_net, capture_data[0]}, 4'h1, "held");
    cap(1'b1);
    chk_sig({3'h0, capture_data[0]}, 4'h1, "rise ignored");
    cap(1'b0);
    chk_sig({3'h0, capture_data[0]}, 4'h0, "fall taken");
    cfg(32'h040);
    pad(1'b1);
    cap(1'b1);
    pad(1'b0);
    cap(1'b0);
    chk_sig({2'h0, capture_data}, 4'h1, "dual in");
    reg_read(gde_pkg::GDE_STAT_OFS);
    chk_reg(rd & 32'h39, 32'h28, "status");
    cfg(32'h0C0);
    cap(1'b1);
    cap(1'b0);
    pad(1'b1);
    cap(1'b1);
    chk_sig({2'h0, capture_data}, 4'h1, "resync pair");
    cap(1'b0);
    chk_sig({2'h0, capture_data}, 4'h1, "resync hold");
    pad(1'b0);
    cap(1'b1);
    chk_sig({2'h0, capture_data}, 4'h2, "resync next");
    cfg(32'h040);
    drv(2'h2, 1'b1);
    lau(1'b1);
    chk_sig({3'h0, pad_out}, 4'h0, "out rise");
    lau(1'b0);
    chk_sig({3'h0, pad_out}, 4'h1, "out fall");
    cfg(32'h0C0);
    lau(1'b1);
    chk_sig({3'h0, pad_out}, 4'h0, "resync rise");
    drv(2'h1, 1'b1);
    lau(1'b0);
    chk_sig({3'h0, pad_out}, 4'h1, "resync fall");
    cfg(32'h106);
    drv(2'h1, 1'b1);
    lau(1'b1);
    chk_sig({2'h0, pad_oe, pad_out}, 4'h2, "invert");
    drv(2'h0, 1'b0);
    lau(1'b0);
    chk_sig({2'h0, pad_oe, pad_out}, 4'h2, "oe held");
    lau(1'b1);
    chk_sig({2'h0, pad_oe, pad_out}, 4'h1, "oe off");
    complete_run();
  end
endmodule
